// ==== core/ssp_pkg.sv ====
/*
  Constants for the scanner status and table-port select register bank.
  Assumes a 32-bit AHB-Lite bus where each 8-bit register takes one aligned word.
*/
package ssp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_IMAGE = 8'h00;
  localparam logic [7:0] IDX_KBYTES = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_TARGET = 8'h03;
  localparam logic [7:0] IDX_SENSE_CFG = 8'h40;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // Status register fields
  localparam int ST_PAPER_ONE = 0;
  localparam int ST_PAPER_TWO = 1;
  localparam int ST_MISC_ONE = 2;
  localparam int ST_MISC_TWO = 3;
  localparam int ST_PAUSE = 4;
  localparam int ST_DROP = 5;
  localparam int NUM_SENSE = 4;

  // Buffered-amount field
  localparam int KB_LSB = 1;
  localparam int KB_MSB = 7;

  // Target register fields
  localparam int TG_SRAM = 0;
  localparam int TG_COL_LSB = 1;
  localparam int TG_COL_MSB = 2;
  localparam logic [2:0] TARGET_RESET = 3'h0;
  localparam logic [1:0] COLOUR_RED = 2'h0;
  localparam logic [1:0] COLOUR_GREEN = 2'h1;
  localparam logic [1:0] COLOUR_BLUE = 2'h2;

  // Sense configuration: one edge-sensitive enable per input
  localparam logic [3:0] SENSE_CFG_RESET = 4'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0]
  {
    SSP_ADDR = 2'b01,
    SSP_DATA = 2'b10
  } ssp_bus_t;

endpackage : ssp_pkg

// ==== core/ssp_sync2.sv ====
/*
  Two-flop synchroniser for one asynchronous level.
  Assumes the input is slow compared with the clock; the first flop is read only by the second.
*/
`timescale 1ns/1ns
module ssp_sync2 (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_async,
  output logic o_sync
);

  logic meta;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end
    else if (i_ce)
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : ssp_sync2

// ==== core/ssp_regs.sv ====
/*
  Register bank: image byte port, buffered amount, status and table-port target,
  reached over AHB-Lite with one wait state per transfer.
  Assumes image byte, buffered count, pause and mode inputs come from logic on i_clk;
  paper sense, misc inputs and the supply monitor are asynchronous pins.
*/
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module ssp_regs
  import ssp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic [7:0] i_image_byte,
  output logic o_image_pop,
  input wire logic [6:0] i_buffered_kbytes,
  input wire logic i_pause_line,
  input wire logic i_paper_sense_input_one,
  input wire logic i_paper_sense_input_two,
  input wire logic i_misc_io_one,
  input wire logic i_misc_io_two,
  input wire logic i_supply_low,
  input wire logic i_single_chan_a,
  input wire logic [1:0] i_gamma_colour,
  output logic o_table_sram,
  output logic [1:0] o_table_colour
);

  ssp_bus_t state;
  logic [7:0] idx;
  logic is_write;
  logic accept;
  logic rd_status;
  logic wr_target;
  logic wr_cfg;
  logic [31:0] next_rdata;
  logic [NUM_SENSE-1:0] sense_async;
  logic [NUM_SENSE-1:0] sense_sync;
  logic [NUM_SENSE-1:0] sense_prev;
  logic [NUM_SENSE-1:0] sense_rise;
  logic [NUM_SENSE-1:0] edge_flag;
  logic [NUM_SENSE-1:0] sense_bits;
  logic [NUM_SENSE-1:0] sense_cfg;
  logic supply_low_sync;
  logic drop_flag;
  logic [2:0] target;

  assign sense_async = {i_misc_io_two, i_misc_io_one, i_paper_sense_input_two, i_paper_sense_input_one};

  genvar g;
  generate
    for (g = 0; g < NUM_SENSE; g++)
    begin : gen_sense_sync
      ssp_sync2 u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_async(sense_async[g]),
        .o_sync(sense_sync[g])
      );
    end
  endgenerate

  ssp_sync2 u_supply_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_async(i_supply_low),
    .o_sync(supply_low_sync)
  );

  // Only take a new address phase while our own data phase is finished
  assign accept = i_hsel && (i_htrans == HTRANS_NONSEQ) && i_hready && o_hreadyout;

  // Bus state: every transfer gets one wait state so read data leave a flop
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= SSP_ADDR;
      o_hreadyout <= 1'b1;
      idx <= 8'h00;
      is_write <= 1'b0;
    end
    else if (i_ce)
    begin
      unique case (state)
        SSP_ADDR:
        begin
          if (accept)
          begin
            state <= SSP_DATA;
            o_hreadyout <= 1'b0;
            idx <= (i_haddr[31:IDX_MSB+1] == '0) ? i_haddr[IDX_MSB:IDX_LSB] : 8'hFF;
            is_write <= i_hwrite;
          end
        end
        SSP_DATA:
        begin
          state <= SSP_ADDR;
          o_hreadyout <= 1'b1;
        end
      endcase
    end
  end

  assign rd_status = (state == SSP_DATA) && !is_write && (idx == IDX_STATUS);
  assign wr_target = (state == SSP_DATA) && is_write && (idx == IDX_TARGET);
  assign wr_cfg = (state == SSP_DATA) && is_write && (idx == IDX_SENSE_CFG);

  // Always OKAY; unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_hresp <= 1'b0;
    end
    else if (i_ce)
    begin
      o_hresp <= 1'b0;
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (idx)
      IDX_IMAGE: next_rdata[7:0] = i_image_byte;
      IDX_KBYTES: next_rdata[KB_MSB:KB_LSB] = i_buffered_kbytes;
      IDX_STATUS:
      begin
        next_rdata[ST_PAPER_TWO:ST_PAPER_ONE] = sense_bits[1:0];
        next_rdata[ST_MISC_TWO:ST_MISC_ONE] = sense_bits[3:2];
        next_rdata[ST_PAUSE] = i_pause_line;
        next_rdata[ST_DROP] = drop_flag;
      end
      IDX_TARGET: next_rdata[TG_COL_MSB:TG_SRAM] = target;
      IDX_SENSE_CFG: next_rdata[NUM_SENSE-1:0] = sense_cfg;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_hrdata <= 32'h0000_0000;
    end
    else if (i_ce && state == SSP_DATA)
    begin
      o_hrdata <= is_write ? 32'h0000_0000 : next_rdata;
    end
  end

  // Pop tells the image buffer to advance; it lines up with the end of the read
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_image_pop <= 1'b0;
    end
    else if (i_ce)
    begin
      o_image_pop <= (state == SSP_DATA) && !is_write && (idx == IDX_IMAGE);
    end
  end

  // Software choice of level or edge capture per input
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sense_cfg <= SENSE_CFG_RESET;
    end
    else if (i_ce && wr_cfg)
    begin
      sense_cfg <= i_hwdata[NUM_SENSE-1:0];
    end
  end

  assign sense_rise = sense_sync & ~sense_prev;

  // A rising edge in the clearing cycle survives: set beats clear
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sense_prev <= '0;
      edge_flag <= '0;
    end
    else if (i_ce)
    begin
      sense_prev <= sense_sync;
      edge_flag <= sense_rise | (edge_flag & ~{NUM_SENSE{rd_status}});
    end
  end

  assign sense_bits = (sense_cfg & edge_flag) | (~sense_cfg & sense_sync);

  // Stays set while the supply is still low, even across a read
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      drop_flag <= 1'b0;
    end
    else if (i_ce)
    begin
      drop_flag <= supply_low_sync | (drop_flag & !rd_status);
    end
  end

  // Only the target register takes writes among the documented four
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      target <= TARGET_RESET;
    end
    else if (i_ce && wr_target)
    begin
      target <= i_hwdata[TG_COL_MSB:TG_SRAM];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_table_sram <= 1'b0;
      o_table_colour <= COLOUR_RED;
    end
    else if (i_ce)
    begin
      o_table_sram <= target[TG_SRAM];
      if (i_single_chan_a && !target[TG_SRAM])
      begin
        o_table_colour <= i_gamma_colour;
      end
      else
      begin
        o_table_colour <= target[TG_COL_MSB:TG_COL_LSB];
      end
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence seq_read_of(logic [7:0] which);
    i_ce && state == SSP_DATA && !is_write && idx == which;
  endsequence

  sequence seq_write_of(logic [7:0] which);
    i_ce && state == SSP_DATA && is_write && idx == which;
  endsequence

  a_bus_one_wait: assert property ((accept && i_ce) |=> !o_hreadyout ##1 (o_hreadyout || !$past(i_ce)))
    else $error("transfer did not finish after one wait state");

  a_image_pop_data: assert property (seq_read_of(IDX_IMAGE)
    |=> o_image_pop && o_hrdata == {24'h0, $past(i_image_byte)})
    else $error("image read did not pop or return the byte");

  a_kbytes_layout: assert property (seq_read_of(IDX_KBYTES)
    |=> o_hrdata == {24'h0, $past(i_buffered_kbytes), 1'b0})
    else $error("buffered amount read has wrong layout");

  a_status_level: assert property (seq_read_of(IDX_STATUS) ##0 (sense_cfg == 4'h0)
    |=> o_hrdata[3:0] == $past(sense_sync))
    else $error("level status bits do not follow inputs");

  a_misc_level: assert property (seq_read_of(IDX_STATUS) ##0 !sense_cfg[ST_MISC_ONE]
    |=> o_hrdata[ST_MISC_ONE] == $past(sense_sync[ST_MISC_ONE]))
    else $error("misc level bit does not follow its input");

  a_misc_edge_clear: assert property (seq_read_of(IDX_STATUS)
    ##0 (sense_cfg[ST_MISC_TWO] && !sense_rise[ST_MISC_TWO]) |=> !edge_flag[ST_MISC_TWO])
    else $error("misc edge bit not cleared by status read");

  a_edge_read_clear: assert property (seq_read_of(IDX_STATUS)
    ##0 (sense_cfg[ST_PAPER_ONE] && !sense_rise[ST_PAPER_ONE]) |=> !edge_flag[ST_PAPER_ONE])
    else $error("paper edge bit not cleared by status read");

  a_edge_report: assert property (seq_read_of(IDX_STATUS) ##0 sense_cfg[ST_PAPER_ONE]
    |=> o_hrdata[ST_PAPER_ONE] == $past(edge_flag[ST_PAPER_ONE]))
    else $error("edge status bit does not show the latch");

  a_edge_set_wins: assert property ((i_ce && sense_rise[ST_MISC_TWO]) |=> edge_flag[ST_MISC_TWO])
    else $error("rising edge not latched");

  a_pause_report: assert property (seq_read_of(IDX_STATUS) |=> o_hrdata[ST_PAUSE] == $past(i_pause_line))
    else $error("pause bit does not show the pause input");

  a_drop_set: assert property ((i_ce && supply_low_sync) |=> drop_flag)
    else $error("supply dip not latched");

  a_drop_sticky: assert property ((i_ce && drop_flag && !rd_status) |=> drop_flag)
    else $error("supply dip flag lost without a read");

  a_drop_read_clear: assert property ((rd_status && i_ce && !supply_low_sync)
    |=> !drop_flag ##1 (!drop_flag || $past(supply_low_sync) || !$past(i_ce)))
    else $error("supply dip flag not cleared by read");

  a_drop_report: assert property (seq_read_of(IDX_STATUS) |=> o_hrdata[ST_DROP] == $past(drop_flag))
    else $error("dip bit does not show the flag");

  a_status_upper_zero: assert property (seq_read_of(IDX_STATUS) |=> o_hrdata[31:ST_DROP+1] == '0)
    else $error("unused status bits not zero");

  a_target_write: assert property (seq_write_of(IDX_TARGET)
    |=> target == $past(i_hwdata[2:0]) ##1 (o_table_sram == target[0] || !$past(i_ce)))
    else $error("target write not applied");

  a_target_readback: assert property (seq_read_of(IDX_TARGET) |=> o_hrdata == {29'h0, $past(target)})
    else $error("target read does not return the register");

  a_sram_follow: assert property (i_ce |=> o_table_sram == $past(target[TG_SRAM]))
    else $error("table select does not follow target bit");

  a_colour_select: assert property ((i_ce && !i_single_chan_a) |=> o_table_colour == $past(target[2:1]))
    else $error("colour does not follow target field");

  a_mode_a_colour: assert property ((i_ce && i_single_chan_a && !target[TG_SRAM])
    |=> o_table_colour == $past(i_gamma_colour))
    else $error("mode A gamma colour not taken from input");

  a_ro_unchanged: assert property ((i_ce && state == SSP_DATA && is_write && idx != IDX_TARGET)
    |=> $stable(target))
    else $error("write to other register changed the target");

  a_write_no_pop: assert property ((i_ce && state == SSP_DATA && is_write) |=> !o_image_pop)
    else $error("write advanced the image buffer");

  a_pop_one_cycle: assert property ((i_ce && o_image_pop) |=> !o_image_pop)
    else $error("image pop longer than one cycle");

  a_unmapped_zero: assert property (seq_read_of(8'hFF) |=> o_hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_hresp_okay: assert property (!o_hresp)
    else $error("response not OKAY");

endmodule : ssp_regs

// ==== testbench/scanner_status_and_port_select_tb.sv ====
/*
  Self-checking bench for the status and table-port select register bank.
  Assumes the bench is the only AHB-Lite master and hready is looped back from the one slave.
*/
`timescale 1ns/1ns
module scanner_status_and_port_select_tb
  import ssp_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] img = 8'h00;
  logic [6:0] kb = 7'h00;
  logic pause = 1'b0;
  logic p1 = 1'b0;
  logic p2 = 1'b0;
  logic m1 = 1'b0;
  logic m2 = 1'b0;
  logic low = 1'b0;
  logic mode_a = 1'b0;
  logic [1:0] gcol = 2'h0;
  logic ce = 1'b1;
  logic hready, hresp, pop, tsram, pop_seen, resp_seen;
  logic [1:0] tcol;
  logic [31:0] hrdata, rd;
  int fails = 0;
  int num_checks = 0;

  ssp_regs dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready), .i_hwdata(hwdata),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_image_byte(img), .o_image_pop(pop),
    .i_buffered_kbytes(kb), .i_pause_line(pause), .i_paper_sense_input_one(p1),
    .i_paper_sense_input_two(p2), .i_misc_io_one(m1), .i_misc_io_two(m2), .i_supply_low(low),
    .i_single_chan_a(mode_a), .i_gamma_colour(gcol), .o_table_sram(tsram), .o_table_colour(tcol));

  initial
  begin
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Reads at the active region of an edge see pre-edge values, i.e. what the edge sampled
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    rd = hrdata;
    pop_seen = pop;
    resp_seen = hresp;
  endtask : xfer

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wt

  initial
  begin
    #100000;
    fails++;
    close_out;
  end

  initial
  begin
    wt(10);
    i_rstn <= 1'b1;
    xfer(0, 32'hC, 0);
    chk("target reset", rd, 32'h0);
    chk("sram reset", 32'(tsram), 32'h0);
    img <= 8'hA5;
    xfer(0, 32'h0, 0);
    chk("image byte", rd, 32'hA5);
    chk("image pop", 32'(pop_seen), 32'h1);
    kb <= 7'h55;
    xfer(0, 32'h4, 0);
    chk("kbytes", rd, 32'hAA);
    chk("no pop", 32'(pop_seen), 32'h0);
    xfer(0, 32'h4, 0);
    chk("kbytes again", rd, 32'hAA);
    for (int i = 0; i < 4; i++)
    begin
      {m2, m1, p2, p1} <= 4'h1 << i;
      wt(4);
      xfer(0, 32'h8, 0);
      chk("status level", rd, 32'h1 << i);
    end
    {m2, m1, p2, p1} <= 4'h0;
    pause <= 1'b1;
    wt(4);
    xfer(0, 32'h8, 0);
    chk("pause", rd, 32'h10);
    pause <= 1'b0;
    low <= 1'b1;
    wt(3);
    low <= 1'b0;
    wt(4);
    xfer(0, 32'h8, 0);
    chk("dip set", rd, 32'h20);
    xfer(0, 32'h8, 0);
    chk("dip cleared", rd, 32'h0);
    // A pulse while the clock enable is low never reaches the synchroniser
    ce <= 1'b0;
    low <= 1'b1;
    wt(4);
    low <= 1'b0;
    wt(2);
    ce <= 1'b1;
    wt(4);
    xfer(0, 32'h8, 0);
    chk("dip frozen", rd, 32'h0);
    xfer(1, 32'h100, 32'hF);
    xfer(0, 32'h100, 0);
    chk("edge cfg", rd, 32'hF);
    p1 <= 1'b1;
    wt(4);
    p1 <= 1'b0;
    m2 <= 1'b1;
    wt(4);
    m2 <= 1'b0;
    wt(4);
    xfer(0, 32'h8, 0);
    chk("edge latched", rd, 32'h9);
    xfer(0, 32'h8, 0);
    chk("edge cleared", rd, 32'h0);
    xfer(1, 32'h100, 32'h0);
    // Writes to read-only places must not disturb them
    xfer(1, 32'h8, 32'hFF);
    xfer(1, 32'h0, 32'hFF);
    xfer(1, 32'h4, 32'hFF);
    chk("ro okay", 32'(resp_seen), 32'h0);
    xfer(0, 32'h4, 0);
    chk("kbytes ro", rd, 32'hAA);
    xfer(0, 32'h8, 0);
    chk("status ro", rd, 32'h0);
    xfer(1, 32'h400, 32'h7);
    xfer(0, 32'h400, 0);
    chk("unmapped", rd, 32'h0);
    chk("unmapped pop", 32'(pop_seen), 32'h0);
    for (int v = 0; v < 8; v++)
    begin
      xfer(1, 32'hC, 32'hFFFFFFF8 | 32'(v));
      xfer(0, 32'hC, 0);
      chk("target", rd, 32'(v));
      wt(2);
      chk("sram select", 32'(tsram), 32'(v & 1));
      chk("colour", 32'(tcol), 32'(v >> 1));
    end
    mode_a <= 1'b1;
    gcol <= 2'h2;
    xfer(1, 32'hC, 32'h2);
    wt(2);
    chk("mode a gamma", 32'(tcol), 32'h2);
    xfer(1, 32'hC, 32'h3);
    wt(2);
    chk("mode a sram", 32'(tcol), 32'h1);
    i_rstn <= 1'b0;
    wt(2);
    i_rstn <= 1'b1;
    xfer(0, 32'hC, 0);
    chk("target after reset", rd, 32'h0);
    chk("sram after reset", 32'(tsram), 32'h0);
    close_out;
  end
endmodule : scanner_status_and_port_select_tb
